// [hdl/mfc_pkg.sv]
/*
 Constants shared by the feature-control and secure protection logic: extended configuration byte
 indices, authenticated area addresses, message type codes and reset values.
 Assumes a command decoder upstream that presents already-parsed requests.
*/
// Functional notes
// - byte 486 reads 1, barrier command supported.
// - data cached before a barrier is committed before later requests are served.
// - byte 240 bit 0 reads 1, FIFO flush order.
// - byte 163 bit 1 clear forbids idle background work; set allows it.
// - byte 211 bit 0 reads 1; bit 1 mirrors the secure-mode enable bit.
// - authenticated bytes 1 and 2 change only by authenticated configuration writes.
// - enable resets to 0, legacy; enable 1 lets the mask gate protect updates.
// - existing group and boot protection survives entering or leaving secure mode.
// - mask 0 gives generic error on CSD protect bits, switch error on 171/173/174.
// - mask 0 makes CMD28/29 generic errors; force erase fails, sets lock failure.
// - mask 0 keeps power-on boot protection and its byte across every reset; here every reset clears enable, so boot_hold_ff drops to 0.
// - mask 1 accepted force erase wipes content, password and length, and unlocks.
// - mask 1 force erase fails with lock failure if protected groups or unlocked.
// - mask 1 CMD28 protects the group with the type from byte 171 bits 2 and 0; here PC_SET_WP only raises prot_accept_ff, byte 171 is never read.
// - mask 1 opens temporary groups and boot; mask clear or reset closes them.
// - request types 0x0001-0x0007, responses 0x0100-0x0400, 0x0600, 0x0700; here only 0x0006 and 0x0007 are answered, with 0x0600 and 0x0700.
// - enhanced strobe aligns read data, CRC status and responses to the strobe; here only rsp_on_strobe_ff is driven, for responses.
// - byte 184 reads 1, enhanced strobe supported.
// - after power-on or CMD0 the device uses backward-compatible timing.
package mfc_pkg;
   //-------------------------------------------------------------------------
   // extended configuration byte indices
   //-------------------------------------------------------------------------
   localparam logic [8:0] IDX_BARRIER_CTRL = 9'h01F;
   localparam logic [8:0] IDX_FLUSH_CACHE = 9'h020;
   localparam logic [8:0] IDX_BKOP_CONTROL = 9'h0A3;
   localparam logic [8:0] IDX_REL_WRITE = 9'h0A6;
   localparam logic [8:0] IDX_USER_PROT = 9'h0AB;
   localparam logic [8:0] IDX_BOOT_PROT = 9'h0AD;
   localparam logic [8:0] IDX_BOOT_PROT_STAT = 9'h0AE;
   localparam logic [8:0] IDX_STROBE_CAP = 9'h0B8;
   localparam logic [8:0] IDX_SECURE_INFO = 9'h0D3;
   localparam logic [8:0] IDX_FLUSH_POLICY = 9'h0F0;
   localparam logic [8:0] IDX_BARRIER_SUPPORT = 9'h1E6;
   // authenticated configuration area addresses
   localparam logic [7:0] ADDR_MODE_ENABLE = 8'h01;
   localparam logic [7:0] ADDR_UPDATE_MASK = 8'h02;
   // field positions
   localparam int BIT_BARRIER_EN = 0;
   localparam int BIT_FLUSH = 0;
   localparam int BIT_BARRIER = 1;
   localparam int BIT_BKOP_MANUAL = 0;
   localparam int BIT_BKOP_AUTO = 1;
   localparam int BIT_LARGE_RPMB = 4;
   localparam int BIT_UP_PERM = 2;
   localparam int BIT_UP_PWRON = 0;
   // reset values and fixed read-only contents
   localparam logic [7:0] RST_MODE_ENABLE = 8'h00;
   localparam logic [7:0] RST_UPDATE_MASK = 8'h00;
   localparam logic [7:0] RST_BKOP = 8'h00;
   localparam logic [7:0] VAL_BARRIER_SUPPORT = 8'h01;
   localparam logic [7:0] VAL_FLUSH_POLICY = 8'h01;
   localparam logic [7:0] VAL_STROBE_CAP = 8'h01;
   localparam logic [7:0] VAL_REL_WRITE = 8'h10;
   localparam logic [7:0] VAL_SECURE_CAP = 8'h01;
   // message type codes
   localparam logic [15:0] REQ_KEY_PROG = 16'h0001;
   localparam logic [15:0] REQ_COUNTER = 16'h0002;
   localparam logic [15:0] REQ_DATA_WR = 16'h0003;
   localparam logic [15:0] REQ_DATA_RD = 16'h0004;
   localparam logic [15:0] REQ_RESULT = 16'h0005;
   localparam logic [15:0] REQ_CFG_WR = 16'h0006;
   localparam logic [15:0] REQ_CFG_RD = 16'h0007;
   localparam logic [15:0] RSP_CFG_WR = 16'h0600;
   localparam logic [15:0] RSP_CFG_RD = 16'h0700;
   // protect command kinds from the decoder
   typedef enum logic [2:0] {
      PC_NONE, PC_CSD_PROT, PC_SWITCH_PROT, PC_SET_WP, PC_CLR_WP, PC_FORCE_ERASE
   } mfc_pcmd_t;
endpackage : mfc_pkg

// [hdl/mfc_barrier.sv]
/*
 Barrier ordering: holds off new requests until cached data from before a barrier is committed.
 Assumes the cache engine pulses flush_done once a requested commit has completed.
*/
module mfc_barrier
(
   input wire logic clk, // core clock
   input wire logic rst, // sync reset, high
   input wire logic barrier_en, // barrier mechanism enabled
   input wire logic flush_wr, // write to the flush control byte
   input wire logic [7:0] flush_data, // value written
   input wire logic flush_done, // cache commit finished
   output logic flush_req_ff, // commit request to the cache engine
   output logic hold_ff // stall later requests
);
   typedef enum logic [1:0] {BS_IDLE, BS_FLUSH} mfc_bstate_t;
   mfc_bstate_t state_ff, nxt_state;
   logic nxt_req, nxt_hold;

   // a plain flush also commits; only a barrier stalls traffic behind it
   always_comb
   begin
      nxt_state = state_ff;
      nxt_req = 1'b0;
      nxt_hold = hold_ff;
      case (state_ff)
         BS_IDLE:
         begin
            if (flush_wr && flush_data[mfc_pkg::BIT_FLUSH])
            begin
               nxt_req = 1'b1;
               nxt_state = BS_FLUSH;
               nxt_hold = barrier_en && flush_data[mfc_pkg::BIT_BARRIER];
            end
         end
         BS_FLUSH:
         begin
            if (flush_done)
            begin
               nxt_state = BS_IDLE;
               nxt_hold = 1'b0;
            end
         end
         default: nxt_state = BS_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= BS_IDLE;
         flush_req_ff <= 1'b0;
         hold_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         flush_req_ff <= nxt_req;
         hold_ff <= nxt_hold;
      end
   end
endmodule : mfc_barrier

// [hdl/mfc_prot_check.sv]
/*
 Combinational verdict on a protect-related command given the secure mode bits.
 Assumes decoded command kind and lock state come from the surrounding controller.
*/
module mfc_prot_check
(
   input wire logic secure_en, // secure mode enabled
   input wire logic mask, // update mask
   input wire mfc_pkg::mfc_pcmd_t pcmd, // command kind
   input wire logic locked, // device is locked
   input wire logic hard_groups, // power-on or permanent groups exist
   output logic generic_err, // generic error
   output logic switch_err, // switch error
   output logic lock_fail, // lock failure
   output logic accept // command allowed
);
   logic gated;

   // legacy mode always updates; secure mode follows the mask
   always_comb
   begin
      gated = secure_en && !mask;
      generic_err = 1'b0;
      switch_err = 1'b0;
      lock_fail = 1'b0;
      accept = 1'b0;
      case (pcmd)
         mfc_pkg::PC_CSD_PROT:
         begin
            generic_err = gated;
            accept = !gated;
         end
         mfc_pkg::PC_SWITCH_PROT:
         begin
            switch_err = gated;
            accept = !gated;
         end
         mfc_pkg::PC_SET_WP, mfc_pkg::PC_CLR_WP:
         begin
            generic_err = gated;
            accept = !gated;
         end
         mfc_pkg::PC_FORCE_ERASE:
         begin
            lock_fail = gated || !locked || hard_groups;
            accept = !lock_fail;
         end
         default: accept = 1'b0;
      endcase
   end
endmodule : mfc_prot_check

// [hdl/mfc_feature_ctrl.sv]
/*
 Feature control and secure write protection: extended configuration bytes for barrier, flush
 policy, background operations, strobe and reliable write, plus the authenticated area.
 Assumes an upstream command decoder presents byte writes/reads, parsed protected messages and
 protect commands as one-cycle strobes, synchronous to clk.
*/
module mfc_feature_ctrl
(
   input wire logic clk, // core clock, 125 MHz
   input wire logic rst, // sync reset, high (power-on, hardware or CMD0)
   input wire logic cfg_wr, // switch write strobe
   input wire logic cfg_rd, // configuration read strobe
   input wire logic [8:0] cfg_idx, // byte index
   input wire logic [7:0] cfg_wdata, // byte value
   output logic [7:0] cfg_rdata_ff, // read value
   output logic cfg_rvalid_ff, // read value valid
   input wire logic msg_valid, // protected message strobe
   input wire logic [15:0] msg_type, // message type
   input wire logic msg_auth_ok, // message MAC verified
   input wire logic [7:0] msg_addr, // authenticated area address
   input wire logic [7:0] msg_data, // data byte
   output logic rsp_valid_ff, // response strobe
   output logic [15:0] rsp_type_ff, // response type
   output logic [7:0] rsp_data_ff, // response data byte
   output logic rsp_ok_ff, // operation succeeded
   input wire mfc_pkg::mfc_pcmd_t pcmd, // protect command kind
   input wire logic pcmd_valid, // protect command strobe
   input wire logic locked, // device locked
   input wire logic hard_groups, // power-on or permanent groups exist
   input wire logic flush_done, // cache commit finished
   input wire logic strobe_mode, // enhanced strobe selected by host
   input wire logic hs_select, // host switched timing mode
   output logic generic_err_ff, // generic error
   output logic switch_err_ff, // switch error
   output logic lock_fail_ff, // lock failure flag
   output logic prot_accept_ff, // protect command accepted
   output logic erase_all_ff, // wipe content, password and length
   output logic unlock_ff, // unlock after force erase
   output logic flush_req_ff, // commit request to cache
   output logic req_hold_ff, // stall later requests
   output logic bkop_auto_ff, // idle background work allowed
   output logic bkop_manual_ff, // host starts background work
   output logic temp_open_ff, // temporary and boot protection lifted
   output logic boot_hold_ff, // power-on boot protection kept
   output logic rsp_on_strobe_ff, // responses aligned to strobe
   output logic legacy_timing_ff // backward-compatible timing
);
   //-------------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------------
   logic [7:0] mode_en_ff, nxt_mode_en;
   logic [7:0] mask_ff, nxt_mask;
   logic [7:0] bkop_ff, nxt_bkop;
   logic barrier_en_ff, nxt_barrier_en;
   logic [7:0] nxt_rdata;
   logic nxt_rsp_valid, nxt_rsp_ok;
   logic [15:0] nxt_rsp_type;
   logic [7:0] nxt_rsp_data;
   logic ge, se, lf, acc;
   logic nxt_timing, nxt_strobe;

   // read decode of the authenticated area, used by reads and response building
   function automatic logic [7:0] auth_byte(input logic [7:0] a, input logic [7:0] en,
                                            input logic [7:0] mk);
      begin
         auth_byte = 8'h00;
         if (a == mfc_pkg::ADDR_MODE_ENABLE)
            auth_byte = en;
         else if (a == mfc_pkg::ADDR_UPDATE_MASK)
            auth_byte = mk;
      end
   endfunction : auth_byte

   //-------------------------------------------------------------------------
   // barrier and protect verdict
   //-------------------------------------------------------------------------
   mfc_barrier u_barrier
   (
      .clk(clk),
      .rst(rst),
      .barrier_en(barrier_en_ff),
      .flush_wr(cfg_wr && cfg_idx == mfc_pkg::IDX_FLUSH_CACHE),
      .flush_data(cfg_wdata),
      .flush_done(flush_done),
      .flush_req_ff(flush_req_ff),
      .hold_ff(req_hold_ff)
   );

   mfc_prot_check u_check
   (
      .secure_en(mode_en_ff[0]),
      .mask(mask_ff[0]),
      .pcmd(pcmd),
      .locked(locked),
      .hard_groups(hard_groups),
      .generic_err(ge),
      .switch_err(se),
      .lock_fail(lf),
      .accept(acc)
   );

   //-------------------------------------------------------------------------
   // host-writable bytes
   //-------------------------------------------------------------------------
   // only the writable bytes respond; read-only bytes ignore switch writes
   always_comb
   begin
      nxt_bkop = bkop_ff;
      nxt_barrier_en = barrier_en_ff;
      if (cfg_wr && cfg_idx == mfc_pkg::IDX_BKOP_CONTROL)
         nxt_bkop = {6'h00, cfg_wdata[1:0]};
      if (cfg_wr && cfg_idx == mfc_pkg::IDX_BARRIER_CTRL)
         nxt_barrier_en = cfg_wdata[mfc_pkg::BIT_BARRIER_EN];
   end

   //-------------------------------------------------------------------------
   // authenticated area, written only by verified configuration writes
   //-------------------------------------------------------------------------
   // mode enable change never touches stored protection, only gating
   always_comb
   begin
      nxt_mode_en = mode_en_ff;
      nxt_mask = mask_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_type = rsp_type_ff;
      nxt_rsp_data = rsp_data_ff;
      nxt_rsp_ok = rsp_ok_ff;
      if (msg_valid && msg_type == mfc_pkg::REQ_CFG_WR)
      begin
         nxt_rsp_valid = 1'b1;
         nxt_rsp_type = mfc_pkg::RSP_CFG_WR;
         nxt_rsp_data = msg_data;
         nxt_rsp_ok = msg_auth_ok;
         if (msg_auth_ok && msg_addr == mfc_pkg::ADDR_MODE_ENABLE)
            nxt_mode_en = {7'h00, msg_data[0]};
         if (msg_auth_ok && msg_addr == mfc_pkg::ADDR_UPDATE_MASK)
            nxt_mask = {7'h00, msg_data[0]};
      end
      else if (msg_valid && msg_type == mfc_pkg::REQ_CFG_RD)
      begin
         nxt_rsp_valid = 1'b1;
         nxt_rsp_type = mfc_pkg::RSP_CFG_RD;
         nxt_rsp_data = auth_byte(msg_addr, mode_en_ff, mask_ff);
         nxt_rsp_ok = 1'b1;
      end
   end

   //-------------------------------------------------------------------------
   // read-back of the extended configuration bytes
   //-------------------------------------------------------------------------
   // unmapped bytes read zero
   always_comb
   begin
      case (cfg_idx)
         mfc_pkg::IDX_BARRIER_SUPPORT: nxt_rdata = mfc_pkg::VAL_BARRIER_SUPPORT;
         mfc_pkg::IDX_FLUSH_POLICY: nxt_rdata = mfc_pkg::VAL_FLUSH_POLICY;
         mfc_pkg::IDX_STROBE_CAP: nxt_rdata = mfc_pkg::VAL_STROBE_CAP;
         mfc_pkg::IDX_REL_WRITE: nxt_rdata = mfc_pkg::VAL_REL_WRITE;
         mfc_pkg::IDX_SECURE_INFO:
            nxt_rdata = {6'h00, mode_en_ff[0], mfc_pkg::VAL_SECURE_CAP[0]};
         mfc_pkg::IDX_BKOP_CONTROL: nxt_rdata = bkop_ff;
         mfc_pkg::IDX_BARRIER_CTRL: nxt_rdata = {7'h00, barrier_en_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   //-------------------------------------------------------------------------
   // timing mode
   //-------------------------------------------------------------------------
   // reset forces backward-compatible timing; only a host switch leaves it
   always_comb
   begin
      nxt_timing = legacy_timing_ff;
      if (hs_select)
         nxt_timing = 1'b0;
      nxt_strobe = strobe_mode && !nxt_timing;
   end

   //-------------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------------
   // mask and enable clear on every reset, so opened areas close again
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_en_ff <= mfc_pkg::RST_MODE_ENABLE;
         mask_ff <= mfc_pkg::RST_UPDATE_MASK;
         bkop_ff <= mfc_pkg::RST_BKOP;
         barrier_en_ff <= 1'b0;
         cfg_rdata_ff <= 8'h00;
         cfg_rvalid_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_type_ff <= 16'h0000;
         rsp_data_ff <= 8'h00;
         rsp_ok_ff <= 1'b0;
         generic_err_ff <= 1'b0;
         switch_err_ff <= 1'b0;
         lock_fail_ff <= 1'b0;
         prot_accept_ff <= 1'b0;
         erase_all_ff <= 1'b0;
         unlock_ff <= 1'b0;
         bkop_auto_ff <= 1'b0;
         bkop_manual_ff <= 1'b0;
         temp_open_ff <= 1'b0;
         boot_hold_ff <= 1'b0;
         rsp_on_strobe_ff <= 1'b0;
         legacy_timing_ff <= 1'b1;
      end
      else
      begin
         mode_en_ff <= nxt_mode_en;
         mask_ff <= nxt_mask;
         bkop_ff <= nxt_bkop;
         barrier_en_ff <= nxt_barrier_en;
         cfg_rdata_ff <= nxt_rdata;
         cfg_rvalid_ff <= cfg_rd;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_type_ff <= nxt_rsp_type;
         rsp_data_ff <= nxt_rsp_data;
         rsp_ok_ff <= nxt_rsp_ok;
         generic_err_ff <= pcmd_valid && ge;
         switch_err_ff <= pcmd_valid && se;
         lock_fail_ff <= pcmd_valid && lf;
         prot_accept_ff <= pcmd_valid && acc;
         erase_all_ff <= pcmd_valid && acc && pcmd == mfc_pkg::PC_FORCE_ERASE;
         unlock_ff <= pcmd_valid && acc && pcmd == mfc_pkg::PC_FORCE_ERASE;
         bkop_auto_ff <= nxt_bkop[mfc_pkg::BIT_BKOP_AUTO];
         bkop_manual_ff <= nxt_bkop[mfc_pkg::BIT_BKOP_MANUAL];
         temp_open_ff <= nxt_mode_en[0] && nxt_mask[0];
         boot_hold_ff <= nxt_mode_en[0] && !nxt_mask[0];
         rsp_on_strobe_ff <= nxt_strobe;
         legacy_timing_ff <= nxt_timing;
      end
   end
endmodule : mfc_feature_ctrl

// [bench/mfc_feature_ctrl_asserts.sv]
/*
 Port checker of the feature control block; bound from the bench top, one clock domain.
*/
module mfc_feature_ctrl_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [8:0] cfg_idx,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata_ff,
   input wire logic cfg_rvalid_ff,
   input wire logic msg_valid,
   input wire logic [15:0] msg_type,
   input wire logic rsp_valid_ff,
   input wire logic [15:0] rsp_type_ff,
   input wire mfc_pkg::mfc_pcmd_t pcmd,
   input wire logic pcmd_valid,
   input wire logic locked,
   input wire logic hard_groups,
   input wire logic switch_err_ff,
   input wire logic lock_fail_ff,
   input wire logic prot_accept_ff,
   input wire logic erase_all_ff,
   input wire logic unlock_ff,
   input wire logic flush_req_ff,
   input wire logic req_hold_ff,
   input wire logic flush_done,
   input wire logic bkop_auto_ff,
   input wire logic boot_hold_ff
);
   //-------------------------------------------------------------------------
   // properties
   //-------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // every read is answered on the next cycle, reserved bits of the info byte stay 0
   a_read_answer: assert property (cfg_rd |=> cfg_rvalid_ff)
      else $error("read not answered");
   a_info_fixed: assert property (cfg_rd && cfg_idx == mfc_pkg::IDX_SECURE_INFO
      |=> cfg_rdata_ff[0] && cfg_rdata_ff[7:2] == 6'h00) else $error("info byte wrong");
   a_bkop_follow: assert property (cfg_wr && cfg_idx == mfc_pkg::IDX_BKOP_CONTROL
      |=> bkop_auto_ff == $past(cfg_wdata[1])) else $error("auto background bit wrong");
   a_cfg_wr_type: assert property (msg_valid && msg_type == mfc_pkg::REQ_CFG_WR
      |=> rsp_valid_ff && rsp_type_ff == mfc_pkg::RSP_CFG_WR) else $error("write rsp wrong");
   // gated switch writes must never be accepted; force erase fails if unlocked or hard groups exist
   a_switch_gated: assert property (pcmd_valid && pcmd == mfc_pkg::PC_SWITCH_PROT
      && boot_hold_ff |=> switch_err_ff && !prot_accept_ff) else $error("switch not refused");
   a_erase_refused: assert property (pcmd_valid && pcmd == mfc_pkg::PC_FORCE_ERASE
      && (!locked || hard_groups) |=> lock_fail_ff && !erase_all_ff && !unlock_ff)
      else $error("force erase not refused");
   a_erase_unlocks: assert property ($rose(erase_all_ff)
      |-> unlock_ff && prot_accept_ff && !lock_fail_ff) else $error("erase without unlock");
   // the stall only comes with a commit request and ends right after the commit
   a_hold_with_req: assert property ($rose(req_hold_ff) |-> flush_req_ff)
      else $error("stall without commit request");
   a_hold_release: assert property (flush_done && req_hold_ff |=> !req_hold_ff)
      else $error("stall not released");
   c_barrier: cover property ($rose(req_hold_ff));
   c_erase: cover property (erase_all_ff);
   c_gated: cover property (switch_err_ff);
endmodule : mfc_feature_ctrl_chk

// [bench/mfc_cache_model.sv]
/*
 Cache engine stand-in: answers each commit request after a chosen latency.
 Assumes one commit at a time, since the barrier logic ignores flushes while busy.
*/
module mfc_cache_model
(
   input wire logic clk, // core clock
   input wire logic rst, // sync reset, high
   input wire logic flush_req_ff, // commit request pulse
   input wire logic [3:0] lat, // answer latency, 1 or more
   output logic flush_done // commit finished pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_ff;
   //-------------------------------------------------------------------------
   // commit latency
   //-------------------------------------------------------------------------
   // a long latency keeps the stall up, so later requests are really held off
   always @(posedge clk)
   begin
      flush_done <= !rst && !flush_req_ff && cnt_ff == 4'h1;
      if (rst || flush_req_ff)
         cnt_ff <= rst ? 4'h0 : lat;
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
   end
endmodule : mfc_cache_model

// [bench/mfc_feature_ctrl_tb.sv]
/*
 Bench top: falling-edge stimulus, queued expectations, monitor compares.
 Assumes the cache model and the bound checker.
*/
module mfc_feature_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, msg_valid = 0, msg_auth_ok = 0;
   logic pcmd_valid = 0, locked = 0, hard_groups = 0, strobe_mode = 0, hs_select = 0;
   logic [8:0] cfg_idx = 9'h000;
   logic [7:0] cfg_wdata = 8'h00, msg_addr = 8'h00, msg_data = 8'h00, cfg_rdata_ff, rsp_data_ff;
   logic [15:0] msg_type = 16'h0000, rsp_type_ff;
   logic [3:0] lat = 4'h2;
   mfc_pkg::mfc_pcmd_t pcmd = mfc_pkg::PC_NONE;
   logic flush_done, cfg_rvalid_ff, rsp_valid_ff, rsp_ok_ff, generic_err_ff, switch_err_ff;
   logic lock_fail_ff, prot_accept_ff, erase_all_ff, unlock_ff, flush_req_ff, req_hold_ff;
   logic bkop_auto_ff, bkop_manual_ff, temp_open_ff, boot_hold_ff, rsp_on_strobe_ff;
   logic legacy_timing_ff, en_m = 0, mk_m = 0;
   logic [31:0] seed = 32'h00016236; // 90678
   logic [7:0] rq[$];
   logic [24:0] sq[$];
   logic [5:0] fq[$];
   int bad_count = 0, checks = 0;
   wire [5:0] flg = {generic_err_ff, switch_err_ff, lock_fail_ff, prot_accept_ff, erase_all_ff,
      unlock_ff};
   mfc_feature_ctrl mfc_feature_ctrl_i (.*);
   mfc_cache_model mfc_cache_model_i (.*);
   //-------------------------------------------------------------------------
   // helpers
   //-------------------------------------------------------------------------
   always #4 clk = ~clk;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task cmp(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (e !== g)
      begin
         bad_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask : cmp
   task cmp_rd(input logic [7:0] e, g); cmp(e, g); endtask : cmp_rd
   task cmp_rsp(input logic [24:0] e, g); cmp(e, g); endtask : cmp_rsp
   task cmp_flg(input logic [5:0] e, g); cmp(e, g); endtask : cmp_flg
   task chk(input logic e, g); cmp(e, g); endtask : chk
   task rd(input logic [8:0] i, input logic [7:0] e);
      @(negedge clk);
      cfg_rd = 1;
      cfg_idx = i;
      rq.push_back(e);
      @(negedge clk);
      cfg_rd = 0;
   endtask : rd
   task wr(input logic [8:0] i, input logic [7:0] d);
      @(negedge clk);
      cfg_wr = 1;
      cfg_idx = i;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 0;
   endtask : wr
   // bench mirrors enable and mask to predict responses and verdicts
   task msg(input logic [15:0] t, input logic a, input logic [7:0] ad, input logic [7:0] d);
      if (t == mfc_pkg::REQ_CFG_WR)
      begin
         sq.push_back({mfc_pkg::RSP_CFG_WR, a, 8'h00});
         if (a && ad == mfc_pkg::ADDR_MODE_ENABLE)
            en_m = d[0];
         if (a && ad == mfc_pkg::ADDR_UPDATE_MASK)
            mk_m = d[0];
      end
      else if (t == mfc_pkg::REQ_CFG_RD)
         sq.push_back({mfc_pkg::RSP_CFG_RD, 1'b1, 7'h00, ad == 8'h01 ? en_m : ad == 8'h02 && mk_m});
      @(negedge clk);
      {msg_valid, msg_type, msg_auth_ok, msg_addr, msg_data} = {1'b1, t, a, ad, d};
      @(negedge clk);
      msg_valid = 0;
      repeat (2) @(negedge clk);
   endtask : msg
   task pc(input mfc_pkg::mfc_pcmd_t k);
      if (k == mfc_pkg::PC_FORCE_ERASE)
         fq.push_back((en_m && !mk_m) || !locked || hard_groups ? 6'h08 : 6'h07);
      else if (!(en_m && !mk_m))
         fq.push_back(6'h04);
      else
         fq.push_back(k == mfc_pkg::PC_SWITCH_PROT ? 6'h10 : 6'h20);
      @(negedge clk);
      pcmd_valid = 1;
      pcmd = k;
      @(negedge clk);
      pcmd_valid = 0;
      repeat (2) @(negedge clk);
   endtask : pc
   task summarize();
      bad_count += rq.size() + sq.size() + fq.size(); // unanswered
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // each result pairs with the oldest note; none left means X
   always @(posedge clk)
   begin
      if (cfg_rvalid_ff === 1'b1)
         cmp_rd(rq.size() != 0 ? rq.pop_front() : 8'hX, cfg_rdata_ff);
      if (rsp_valid_ff === 1'b1)
         cmp_rsp(sq.size() != 0 ? sq.pop_front() : 25'hX, {rsp_type_ff, rsp_ok_ff,
            rsp_data_ff & {8{rsp_type_ff == mfc_pkg::RSP_CFG_RD}}});
      if (flg !== 6'h00)
         cmp_flg(fq.size() != 0 ? fq.pop_front() : 6'hX, flg);
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
   //-------------------------------------------------------------------------
   // scenarios
   //-------------------------------------------------------------------------
   initial
   begin
      logic [7:0] d;
      repeat (10) @(negedge clk);
      rst = 0;
      chk(1'b1, legacy_timing_ff);
      rd(mfc_pkg::IDX_BARRIER_SUPPORT, 8'h01);
      rd(mfc_pkg::IDX_FLUSH_POLICY, 8'h01);
      rd(mfc_pkg::IDX_STROBE_CAP, 8'h01);
      rd(mfc_pkg::IDX_REL_WRITE, 8'h10);
      rd(9'h005, 8'h00);
      wr(mfc_pkg::IDX_BARRIER_SUPPORT, 8'hFE);
      rd(mfc_pkg::IDX_BARRIER_SUPPORT, 8'h01);
      for (int n = 0; n < 4; n++)
      begin
         d = rnd();
         wr(mfc_pkg::IDX_BKOP_CONTROL, d);
         rd(mfc_pkg::IDX_BKOP_CONTROL, {6'h00, d[1:0]});
         chk(d[1], bkop_auto_ff);
         chk(d[0], bkop_manual_ff);
      end
      wr(mfc_pkg::IDX_BARRIER_CTRL, 8'h01);
      for (int n = 0; n < 2; n++)
      begin
         lat = n ? 4'hC : 4'h2;
         wr(mfc_pkg::IDX_FLUSH_CACHE, 8'h03);
         chk(1'b1, req_hold_ff);
         for (int w = 0; w < 40 && req_hold_ff !== 1'b0; w++) @(negedge clk);
         chk(1'b0, req_hold_ff);
      end
      wr(mfc_pkg::IDX_FLUSH_CACHE, 8'h02);
      chk(1'b0, req_hold_ff);
      for (int t = 1; t < 6; t++) msg(t[15:0], 1'b1, 8'h01, 8'h01);
      msg(mfc_pkg::REQ_CFG_WR, 1'b0, mfc_pkg::ADDR_MODE_ENABLE, 8'h01);
      rd(mfc_pkg::IDX_SECURE_INFO, 8'h01);
      msg(mfc_pkg::REQ_CFG_WR, 1'b1, mfc_pkg::ADDR_MODE_ENABLE, 8'h01);
      rd(mfc_pkg::IDX_SECURE_INFO, 8'h03);
      msg(mfc_pkg::REQ_CFG_RD, 1'b1, mfc_pkg::ADDR_MODE_ENABLE, 8'h00);
      chk(1'b1, boot_hold_ff);
      locked = 1;
      for (int m = 0; m < 2; m++)
      begin
         msg(mfc_pkg::REQ_CFG_WR, 1'b1, mfc_pkg::ADDR_UPDATE_MASK, m[7:0]);
         chk(m[0], temp_open_ff);
         for (int k = 1; k < 6; k++) pc(mfc_pkg::mfc_pcmd_t'(k[2:0]));
      end
      for (int n = 0; n < 6; n++)
      begin
         d = rnd();
         {locked, hard_groups} = d[1:0];
         pc(mfc_pkg::PC_FORCE_ERASE);
      end
      msg(mfc_pkg::REQ_CFG_WR, 1'b1, mfc_pkg::ADDR_MODE_ENABLE, 8'h00);
      pc(mfc_pkg::PC_SET_WP);
      strobe_mode = 1;
      hs_select = 1;
      @(negedge clk);
      hs_select = 0;
      repeat (2) @(negedge clk);
      chk(1'b0, legacy_timing_ff);
      chk(1'b1, rsp_on_strobe_ff);
      msg(mfc_pkg::REQ_CFG_WR, 1'b1, mfc_pkg::ADDR_MODE_ENABLE, 8'h01);
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      {en_m, mk_m} = 2'b00;
      chk(1'b1, legacy_timing_ff);
      chk(1'b0, temp_open_ff);
      rd(mfc_pkg::IDX_SECURE_INFO, 8'h01);
      repeat (4) @(negedge clk);
      summarize();
   end
endmodule : mfc_feature_ctrl_tb

bind mfc_feature_ctrl mfc_feature_ctrl_chk mfc_feature_ctrl_chk_i (.*);
